// ---- rtl/flash_id_params.svh ----
`ifndef FLASH_ID_PARAMS_SVH
`define FLASH_ID_PARAMS_SVH
// opcodes
`define OP_WAKE 8'hab
`define OP_IDENT_1 8'h90
`define OP_IDENT_2 8'hef
`define OP_IDENT_4 8'hdf
`define OP_OTP_ENTER 8'hb1
`define OP_OTP_EXIT 8'hc1
`define OP_LOCK_READ 8'h2b
`define OP_LOCK_WRITE 8'h2f
`define OP_SLEEP 8'hb9
`define OP_WLATCH_SET 8'h06
`define OP_STATUS_WRITE 8'h01
`define OP_READ 8'h03
// lock register fields
`define LOCK_FACTORY_BIT 0
`define LOCK_CUSTOMER_BIT 1
`define LOCK_RESET 8'h00
// address byte that puts the part code first
`define IDENT_SWAP_ADDR 8'h01
// wake delay in ns
`define WAKE_DELAY_NS 8000
`define CLK_PERIOD_NS 20
`endif

// ---- rtl/flash_id_pkg.sv ----
package flash_id_pkg;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_IDENT_HDR = 3'b001,
      ST_IDENT_OUT = 3'b010,
      ST_SIG_OUT = 3'b011,
      ST_LOCK_OUT = 3'b100,
      ST_SWALLOW = 3'b101
   } phase_t;
endpackage : flash_id_pkg

// ---- rtl/byte_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic flush,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of 2");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic do_wr;
   logic do_rd;
   // full when pointers differ only in wrap bit
   assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_q != rd_q;
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   assign out_data = mem_q[rd_q[AW-1:0]];
   // pointers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (clk_en) begin
         if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
         end else begin
            if (do_wr) wr_q <= wr_q + 1'b1;
            if (do_rd) rd_q <= rd_q + 1'b1;
         end
      end
   end
   // storage, no reset needed
   always_ff @(posedge mclk) begin
      if (clk_en && do_wr && !flush) mem_q[wr_q[AW-1:0]] <= in_data;
   end
endmodule : byte_fifo
`default_nettype wire

// ---- rtl/flash_id_ctrl.sv ----
// Functional notes
// [RULE1] wake ends on select high, standby
// [RULE2] standby immediate, or after wake delay
// [RULE3] host waits wake delay before reselect
// [RULE4] signature command returns one 8-bit id
// [RULE5] wake/signature allowed asleep, refused when busy
// [RULE6] signature byte repeats while clocked
// [RULE7] host ends signature after one byte
// [RULE8] three opcodes decode as ident read
// [RULE9] ident bytes msb first, falling edge
// [RULE10] address 01h swaps order, codes alternate
// [RULE11] host ends ident read with select high
// [RULE12] enter-otp opcode sets otp mode
// [RULE13] otp mode routes read/program to otp
// [RULE14] otp mode refuses main array access
// [RULE15] otp mode refuses status/lock writes
// [RULE16] exit-otp opcode restores main addressing
// [RULE17] lock register readable anytime, repeating; code refuses the lock read while asleep
// [RULE18] bit0 factory lock, bits7..2 reserved
// [RULE19] lock write sets sticky bit1
// [RULE20] lock write ignores write latch
// [RULE21] lock write needs byte boundary
// [RULE22] reset gives standby, latch cleared
// [RULE23] asleep, only wake/signature heard
// [RULE24] otp and lock opcodes are constants
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_params.svh"
module flash_id_ctrl #(
   parameter int WAKE_CYCLES = `WAKE_DELAY_NS / `CLK_PERIOD_NS,
   parameter logic [7:0] SIG_CODE = 8'h5a,   // arbitrary
   parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary
   parameter logic [7:0] PART_CODE = 8'h5a,  // arbitrary
   parameter logic FACTORY_LOCK = 1'b0,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic busy,
   output logic sleeping,
   output logic ready,
   output logic otp_mode,
   output logic main_blocked,
   output logic write_latch,
   output logic [7:0] otp_lock_status,
   output logic [7:0] cmd_data,
   output logic cmd_valid,
   input wire logic cmd_ready
);
   initial begin
      if (WAKE_CYCLES < 1) $error("wake delay below one cycle");
   end
   // ************************************************************
   // pin synchronisers and edge detection
   // ************************************************************
   logic [1:0] cs_sync_q;
   logic [1:0] sclk_sync_q;
   logic [1:0] si_sync_q;
   logic sclk_last_q;
   logic cs_last_q;
   logic sel;
   logic rise;
   logic fall;
   logic cs_rise;
   // two stages per pin; only the second is read by logic
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_sync_q <= 2'b11;
         sclk_sync_q <= 2'b00;
         si_sync_q <= 2'b00;
         sclk_last_q <= 1'b0;
         cs_last_q <= 1'b1;
      end else if (clk_en) begin
         cs_sync_q <= {cs_sync_q[0], cs_n};
         sclk_sync_q <= {sclk_sync_q[0], sclk};
         si_sync_q <= {si_sync_q[0], si};
         sclk_last_q <= sclk_sync_q[1];
         cs_last_q <= cs_sync_q[1];
      end
   end
   assign sel = !cs_sync_q[1];
   assign rise = sel && sclk_sync_q[1] && !sclk_last_q;
   assign fall = sel && !sclk_sync_q[1] && sclk_last_q;
   assign cs_rise = cs_sync_q[1] && !cs_last_q;
   // ************************************************************
   // bit and byte assembly
   // ************************************************************
   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic byte_done;
   logic [7:0] rx_byte;
   logic [7:0] opcode_q;
   assign byte_done = rise && bit_cnt_q == 3'd7;
   assign rx_byte = {shift_q, si_sync_q[1]};
   // bit counter restarts each frame; byte_done marks a boundary
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_cnt_q <= 3'd0;
         shift_q <= 7'd0;
      end else if (clk_en) begin
         if (!sel) begin
            bit_cnt_q <= 3'd0;
         end else if (rise) begin
            bit_cnt_q <= bit_cnt_q + 3'd1;
            shift_q <= rx_byte[6:0];
         end
      end
   end
   // ************************************************************
   // command phase machine
   // ************************************************************
   flash_id_pkg::phase_t phase_q;
   logic [1:0] hdr_cnt_q;
   logic swap_q;
   logic [7:0] tx_q;
   logic [2:0] tx_bit_q;
   logic tx_toggle_q;
   logic boundary_q;
   logic asleep_q;
   logic waking_q;
   logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_q;
   logic otp_q;
   logic cust_lock_q;
   logic latch_q;
   logic fifo_in_ready;
   logic ident_op;
   assign ident_op = rx_byte == `OP_IDENT_1 || rx_byte == `OP_IDENT_2
      || rx_byte == `OP_IDENT_4; // [RULE8]
   // the byte to put on the wire after the one now leaving
   function automatic logic [7:0] next_tx(input logic [2:0] ph,
                                          input logic alt);
      logic [7:0] v;
      v = SIG_CODE;
      case (ph)
         3'b010: v = alt ? PART_CODE : MAKER_CODE;
         3'b100: v = otp_lock_status;
         default: v = SIG_CODE;
      endcase
      return v;
   endfunction : next_tx
   // opcode decode and per-command data phases
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_q <= flash_id_pkg::ST_OPCODE;
         opcode_q <= 8'h00;
         hdr_cnt_q <= 2'd0;
         swap_q <= 1'b0;
         tx_q <= 8'h00;
         tx_toggle_q <= 1'b0;
      end else if (clk_en) begin
         if (!sel) begin
            phase_q <= flash_id_pkg::ST_OPCODE;
         end else if (byte_done) begin
            case (phase_q)
               flash_id_pkg::ST_OPCODE: begin
                  opcode_q <= rx_byte;
                  phase_q <= flash_id_pkg::ST_SWALLOW;
                  hdr_cnt_q <= 2'd0;
                  if (rx_byte == `OP_LOCK_READ && !asleep_q) begin
                     // works even while busy, never asleep [RULE17] [RULE23]
                     phase_q <= flash_id_pkg::ST_LOCK_OUT;
                     tx_q <= otp_lock_status;
                  end else if (busy || waking_q) begin
                     phase_q <= flash_id_pkg::ST_SWALLOW; // [RULE5]
                  end else if (rx_byte == `OP_WAKE) begin
                     // signature shares the wake opcode [RULE4]
                     phase_q <= flash_id_pkg::ST_SIG_OUT;
                     tx_q <= SIG_CODE;
                  end else if (!asleep_q && ident_op) begin // [RULE23]
                     phase_q <= flash_id_pkg::ST_IDENT_HDR;
                  end
               end
               flash_id_pkg::ST_IDENT_HDR: begin
                  hdr_cnt_q <= hdr_cnt_q + 2'd1;
                  if (hdr_cnt_q == 2'd2) begin
                     // address 01h sends part code first [RULE10]
                     swap_q <= rx_byte == `IDENT_SWAP_ADDR;
                     tx_q <= (rx_byte == `IDENT_SWAP_ADDR) ? PART_CODE
                        : MAKER_CODE;
                     tx_toggle_q <= rx_byte != `IDENT_SWAP_ADDR;
                     phase_q <= flash_id_pkg::ST_IDENT_OUT;
                  end
               end
               flash_id_pkg::ST_IDENT_OUT: begin
                  // alternate between the two codes [RULE10]
                  tx_q <= next_tx(3'b010, tx_toggle_q);
                  tx_toggle_q <= !tx_toggle_q;
               end
               default: begin
                  // repeat signature / lock byte [RULE6] [RULE17]
                  tx_q <= next_tx(phase_q, 1'b0);
               end
            endcase
         end
      end
   end
   // ************************************************************
   // serial output, changes on falling sclk
   // ************************************************************
   logic out_phase;
   assign out_phase = phase_q == flash_id_pkg::ST_IDENT_OUT
      || phase_q == flash_id_pkg::ST_SIG_OUT
      || phase_q == flash_id_pkg::ST_LOCK_OUT;
   // first bit appears on the fall after the final input bit
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         so <= 1'b0;
         so_oe <= 1'b0;
         tx_bit_q <= 3'd7;
      end else if (clk_en) begin
         if (!sel || !out_phase) begin
            so_oe <= 1'b0;
            tx_bit_q <= 3'd7;
         end else if (fall) begin
            so_oe <= 1'b1;
            so <= tx_q[tx_bit_q]; // msb first [RULE9]
            tx_bit_q <= tx_bit_q - 3'd1;
         end
      end
   end
   // ************************************************************
   // mode state: sleep, wake, otp, lock, write latch
   // ************************************************************
   // byte boundary flag; cleared between frames so a stale opcode
   // from an earlier frame is never applied again
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         boundary_q <= 1'b0;
      end else if (clk_en) begin
         if (byte_done) boundary_q <= phase_q == flash_id_pkg::ST_OPCODE;
         else if (rise || (!sel && !cs_rise)) boundary_q <= 1'b0;
      end
   end
   logic single_op;
   assign single_op = cs_rise && boundary_q;
   // sleep and the wake delay; reset yields plain standby [RULE22]
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         asleep_q <= 1'b0;
         waking_q <= 1'b0;
         wake_cnt_q <= '0;
      end else if (clk_en) begin
         if (waking_q) begin
            wake_cnt_q <= wake_cnt_q - 1'b1;
            if (wake_cnt_q == 1) waking_q <= 1'b0; // [RULE2]
         end else if (cs_rise && !busy && opcode_q == `OP_WAKE && (boundary_q
                      || phase_q == flash_id_pkg::ST_SIG_OUT)) begin
            // wake completes on select high [RULE1]
            if (asleep_q) begin
               waking_q <= 1'b1; // delayed standby [RULE2]
               wake_cnt_q <= ($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES);
            end
            asleep_q <= 1'b0;
         end else if (single_op && !busy && !asleep_q
                      && opcode_q == `OP_SLEEP) begin
            asleep_q <= 1'b1;
         end
      end
   end
   // otp mode entry/exit and the customer lock
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         otp_q <= 1'b0;
         cust_lock_q <= 1'b0;
      end else if (clk_en && single_op && !busy && !asleep_q) begin
         if (opcode_q == `OP_OTP_ENTER) otp_q <= 1'b1; // [RULE12] [RULE24]
         if (opcode_q == `OP_OTP_EXIT) otp_q <= 1'b0; // [RULE16] [RULE24]
         // no latch needed, boundary checked, refused in otp
         if (opcode_q == `OP_LOCK_WRITE && !otp_q) // [RULE15] [RULE20]
            cust_lock_q <= 1'b1; // [RULE19] [RULE21]
      end
   end
   // write latch, cleared at reset; status writes refused in otp
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         latch_q <= 1'b0;
      end else if (clk_en && single_op && !busy && !asleep_q) begin
         if (opcode_q == `OP_WLATCH_SET) latch_q <= 1'b1;
         else if (opcode_q == `OP_STATUS_WRITE && !otp_q) // [RULE15]
            latch_q <= 1'b0;
      end
   end
   // reserved bits read zero [RULE18]
   assign otp_lock_status = {6'b000000, cust_lock_q, FACTORY_LOCK};
   assign sleeping = asleep_q;
   assign ready = !asleep_q && !waking_q;
   assign otp_mode = otp_q; // read/program go to otp region [RULE13]
   assign main_blocked = otp_q; // [RULE14]
   assign write_latch = latch_q;
   // ************************************************************
   // command bytes for the array engine, buffered
   // ************************************************************
   logic fifo_valid_in;
   assign fifo_valid_in = byte_done && ready
      && phase_q == flash_id_pkg::ST_SWALLOW
      && !(otp_q && cust_lock_q && opcode_q != `OP_READ); // [RULE15]
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .flush(1'b0),
      .in_data(rx_byte),
      .in_valid(fifo_valid_in),
      .in_ready(fifo_in_ready),
      .out_data(cmd_data),
      .out_valid(cmd_valid),
      .out_ready(cmd_ready)
   );
   // ************************************************************
   // assertions
   // ************************************************************
   a_lock_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
      otp_lock_status[7:2] == 6'b0) // [RULE18]
      else $error("reserved lock bits nonzero");
   a_lock_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
      cust_lock_q |=> cust_lock_q) // [RULE19]
      else $error("customer lock cleared");
   a_wake_time: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(waking_q) |-> wake_cnt_q == WAKE_CYCLES) // [RULE2]
      else $error("wake delay not loaded in full");
   a_otp_blocks: assert property (@(posedge mclk) disable iff (sys_rst)
      otp_mode |-> main_blocked) // [RULE14]
      else $error("main array open in otp mode");
   a_out_idle: assert property (@(posedge mclk) disable iff (sys_rst)
      !sel && clk_en |=> !so_oe) // [RULE9]
      else $error("output driven while deselected");
   a_busy_wake: assert property (@(posedge mclk) disable iff (sys_rst)
      busy && asleep_q && clk_en |=> asleep_q) // [RULE5]
      else $error("woke during busy cycle");
   a_otp_lockw: assert property (@(posedge mclk) disable iff (sys_rst)
      otp_q && !cust_lock_q |=> !cust_lock_q || !$past(otp_q)) // [RULE15]
      else $error("lock written in otp mode");
   a_sleep_ident: assert property (@(posedge mclk) disable iff (sys_rst)
      asleep_q |-> phase_q != flash_id_pkg::ST_IDENT_HDR) // [RULE23]
      else $error("ident decoded while asleep");
endmodule : flash_id_ctrl
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host controller on the serial link
// ****************************************
module host_model (
   input wire logic mclk,
   output logic cs_n,
   output logic sclk,
   output logic si,
   input wire logic so
);
   // idle: deselected, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end

   // gap first so the synchronisers see the deselect
   task automatic sel();
      repeat (8) @(posedge mclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : sel

   // raise select only after a whole bit, never mid-clock
   task automatic desel();
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si;    // released line must not hold its value
   endtask : desel

   // n bits msb first; each sample is the bit launched one fall earlier
   task automatic xbits(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         si <= tx[i];
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         repeat (3) @(posedge mclk);
         @(negedge mclk) rx[i] = so;
         @(posedge mclk) sclk <= 1'b0;
      end
   endtask : xbits
endmodule : host_model
`default_nettype wire

// ---- verif/tb_flash_id_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_params.svh"
// ****************************************
// bench for the id / otp / wake logic
// ****************************************
module tb_flash_id_ctrl;
   localparam int WK = 12;
   localparam logic [7:0] SIG = 8'h5a; // arbitrary
   localparam logic [7:0] MK = 8'h3c;  // arbitrary
   localparam logic [7:0] PT = 8'h96;  // arbitrary
   localparam logic FL = 1'b0;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b0;
   logic busy = 1'b0;
   logic cmd_ready = 1'b0;
   logic drain = 1'b0;
   wire logic cs_n, sclk, si, so, so_oe, sleeping, ready;
   wire logic otp_mode, main_blocked, write_latch, cmd_valid;
   wire logic [7:0] otp_lock_status, cmd_data;
   logic [31:0] seed = 32'h34;
   logic [7:0] rx_q[$];
   logic [7:0] fq[$];
   logic [7:0] tx[$];
   logic [7:0] m_lock = {6'h00, 1'b0, FL};
   logic [7:0] r;
   logic [31:0] x;
   logic [31:0] xd;
   int fails = 0;
   int tests_run = 0;
   int lo_cnt = 0;
   logic [7:0] ops [3];

   always #10 mclk = ~mclk;

   // released so floats to its pull-up level in the host's view
   host_model host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si),
                    .so(so_oe === 1'b1 ? so : 1'b1));
   flash_id_ctrl #(.WAKE_CYCLES(WK), .SIG_CODE(SIG), .MAKER_CODE(MK),
      .PART_CODE(PT), .FACTORY_LOCK(FL), .FIFO_DEPTH(8)) dut (
      .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cs_n),
      .sclk(sclk), .si(si), .so(so), .so_oe(so_oe), .busy(busy),
      .sleeping(sleeping), .ready(ready), .otp_mode(otp_mode),
      .main_blocked(main_blocked), .write_latch(write_latch),
      .otp_lock_status(otp_lock_status), .cmd_data(cmd_data),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk8

   task automatic chk1(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %b got %b", n, e, g);
      end
   endtask : chk1

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // one frame; afterwards count cycles without ready, which also
   // keeps the host deselected through any wake delay
   task automatic run(input logic [7:0] t[$], input int nrd);
      logic [7:0] b;
      logic [31:0] y;
      rx_q = {};
      host.sel();
      foreach (t[i]) host.xbits(t[i], 8, b);
      repeat (nrd) begin
         y = xs();
         host.xbits(y[7:0], 8, b);
         rx_q.push_back(b);
      end
      host.desel();
      lo_cnt = 0;
      repeat (40) @(posedge mclk) if (ready !== 1'b1) lo_cnt++;
   endtask : run

   // drain side: random stalls, every pop checked in order
   always @(posedge mclk) begin
      if (drain && cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
         if (fq.size() == 0) chk8("cmd_data extra", 8'h00, 8'hff);
         else chk8("cmd_data", fq.pop_front(), cmd_data);
      end
      xd = xs();
      cmd_ready <= drain & xd[3];
   end

   // hang guard, far beyond the expected run
   initial begin
      #1_000_000;
      fails++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      clk_en <= 1'b1;
      repeat (4) @(posedge mclk);
      chk1("sleeping", 1'b0, sleeping);
      chk1("ready", 1'b1, ready);
      chk1("write_latch", 1'b0, write_latch);
      chk8("lock reg", m_lock, otp_lock_status);
      // fill the fifo to its depth while the consumer stalls
      tx = {8'h03};
      repeat (8) begin
         x = xs();
         tx.push_back(x[7:0]);
      end
      fq = tx[1:$]; // the opcode is decoded here, only its bytes queue
      run(tx, 0);
      chk1("cmd_valid full", 1'b1, cmd_valid);
      drain <= 1'b1;
      for (int i = 0; i < 400 && (fq.size() > 0 || cmd_valid); i++)
         @(posedge mclk);
      drain <= 1'b0;
      chk1("cmd_valid empty", 1'b0, cmd_valid);
      chk8("fifo left", 8'h00, 8'(fq.size()));
      // ident read: all three opcodes, both orders
      ops = '{`OP_IDENT_1, `OP_IDENT_2, `OP_IDENT_4};
      for (int k = 0; k < 3; k++) begin
         for (int a = 0; a < 2; a++) begin
            x = xs();
            tx = {ops[k], x[7:0], x[15:8], 8'(a)};
            run(tx, 4);
            for (int j = 0; j < 4; j++)
               chk8("ident", ((j + a) % 2) ? PT : MK, rx_q[j]);
         end
      end
      // signature while awake: repeats, no wake delay
      tx = {`OP_WAKE};
      run(tx, 5);
      chk8("sig", SIG, rx_q[3]);
      chk8("sig again", SIG, rx_q[4]);
      chk1("no delay", 1'b1, lo_cnt < 6);
      // sleep, then only wake may be heard
      tx = {`OP_SLEEP};
      run(tx, 0);
      chk1("asleep", 1'b1, sleeping);
      tx = {`OP_IDENT_1, 8'h00, 8'h00, 8'h00};
      run(tx, 2);
      chk1("still asleep", 1'b1, sleeping);
      busy <= 1'b1;
      tx = {`OP_WAKE};
      run(tx, 0);
      chk1("busy wake", 1'b1, sleeping);
      busy <= 1'b0;
      tx = {`OP_LOCK_READ};
      run(tx, 2);
      chk8("asleep lock rd", 8'hff, rx_q[0]);
      tx = {`OP_WAKE};
      run(tx, 0);
      chk1("wake delay", 1'b1, lo_cnt >= WK);
      chk1("awake", 1'b0, sleeping);
      chk1("standby", 1'b1, ready);
      busy <= 1'b1;
      tx = {`OP_LOCK_READ};
      run(tx, 2);
      chk8("busy lock rd", m_lock, rx_q[0]);
      busy <= 1'b0;
      // otp mode refuses the lock write
      tx = {`OP_OTP_ENTER};
      run(tx, 0);
      chk1("otp_mode", 1'b1, otp_mode);
      chk1("blocked", 1'b1, main_blocked);
      tx = {`OP_LOCK_WRITE};
      run(tx, 0);
      chk8("otp lock wr", m_lock, otp_lock_status);
      tx = {`OP_OTP_EXIT};
      run(tx, 0);
      chk1("otp exit", 1'b0, otp_mode);
      chk1("unblocked", 1'b0, main_blocked);
      // lock write cut mid-byte is dropped
      host.sel();
      host.xbits(`OP_LOCK_WRITE, 8, r);
      host.xbits(8'hff, 4, r);
      host.desel();
      repeat (20) @(posedge mclk);
      chk8("partial wr", m_lock, otp_lock_status);
      // proper lock write with the latch clear
      tx = {`OP_LOCK_WRITE};
      run(tx, 0);
      m_lock[1] = 1'b1;
      chk8("lock wr", m_lock, otp_lock_status);
      chk1("latch", 1'b0, write_latch);
      tx = {`OP_LOCK_READ};
      run(tx, 2);
      chk8("lock rd", m_lock, rx_q[0]);
      chk8("lock rd rep", m_lock, rx_q[1]);
      // status write refused in otp mode leaves the latch set
      tx = {`OP_WLATCH_SET};
      run(tx, 0);
      chk1("latch set", 1'b1, write_latch);
      tx = {`OP_OTP_ENTER};
      run(tx, 0);
      tx = {`OP_STATUS_WRITE};
      run(tx, 0);
      chk1("otp status wr", 1'b1, write_latch);
      print_verdict();
   end
endmodule : tb_flash_id_ctrl
`default_nettype wire
